//--- hw/rtc_consts.vh
// Constants for the real-time counter compare, task and readback logic
`ifndef RTC_CONSTS_VH
`define RTC_CONSTS_VH

`define CNT_W            24
`define PRESC_W          12
`define CMP_CHANNELS     4
`define CNT_RESET        24'h000000
`define CNT_NEAR_WRAP    24'hfffff0
`define CNT_MAX          24'hffffff
`define PRESC_ZERO       12'h000
`define CLK_PERIOD_PS    10000
`define TASK_DLY_MIN_PS  15258500
`define TASK_DLY_MAX_PS  45775500
`define TASK_DLY_MIN_CYC ((`TASK_DLY_MIN_PS + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define TASK_DLY_MAX_CYC (`TASK_DLY_MAX_PS / `CLK_PERIOD_PS)
`define RD_STALL_CYC     3'd3
`define RD_CAPTURE_CYC   3'd2
`define RD_TOTAL_CYC     5

`endif

//--- hw/rtc_cmp_channel.v
// One compare channel: bus-side value, slow-domain mirror and match pulse
`timescale 1ns/1ps
`default_nettype none
`include "rtc_consts.vh"

module rtc_cmp_channel (
    input  wire                 core_clk,
    input  wire                 srst,
    input  wire                 wr,
    input  wire [`CNT_W-1:0]    wdata,
    input  wire                 lf_rise,
    input  wire                 inc,
    input  wire [`CNT_W-1:0]    cnt_next,
    output reg  [`CNT_W-1:0]    value,
    output reg                  match
);

    reg [`CNT_W-1:0] mirror_r;

    // Bus value, mirrored into the slow domain only at a slow rising edge
    always @(posedge core_clk) begin
        if (srst) begin
            value    <= `CNT_RESET;
            mirror_r <= `CNT_RESET;
            match    <= 1'b0;
        end else begin
            if (wr) begin
                value <= wdata;
            end
            // Compare uses the old mirror at this edge, new value next edge
            match <= lf_rise & inc & (cnt_next == mirror_r);
            if (lf_rise) begin
                mirror_r <= value;
            end
        end
    end

endmodule
`default_nettype wire

//--- hw/rtc_core.v
// Real-time counter core: task delays, counter, compare events and stalled read
`timescale 1ns/1ps
`default_nettype none
`include "rtc_consts.vh"

module rtc_core (
    input  wire                       core_clk,
    input  wire                       srst,
    input  wire                       low_freq_clock,
    input  wire                       task_start,
    input  wire                       task_stop,
    input  wire                       task_clear,
    input  wire                       task_force_near_overflow,
    input  wire [`PRESC_W-1:0]        prescaler,
    input  wire [`CMP_CHANNELS-1:0]   cmp_wr,
    input  wire [`CNT_W-1:0]          cmp_wdata,
    input  wire                       rd_sel,
    input  wire                       rd_enable,
    output wire                       pready,
    output reg  [`CNT_W-1:0]          rd_data,
    output wire                       lf_clk_req,
    output reg                        running,
    output reg                        increment_event,
    output reg                        wrap_event,
    output wire [`CMP_CHANNELS-1:0]   compare_event
);

    // Task slots: 0 start, 1 stop, 2 clear, 3 force near overflow
    reg  [3:0]              pend_r;
    reg  [3:0]              fall_seen_r;
    reg                     lf_q_r;
    reg  [`CNT_W-1:0]       cnt_r;
    reg  [`PRESC_W-1:0]     presc_r;
    reg  [2:0]              rd_cnt_r;
    wire                    lf_rise;
    wire                    lf_fall;
    wire [3:0]              task_in;
    wire [3:0]              fire;
    wire                    inc;
    wire [`CNT_W-1:0]       cnt_next;

    assign task_in = {task_force_near_overflow, task_clear, task_stop, task_start};

    // Slow clock edges seen on the fast clock
    assign lf_rise = low_freq_clock & ~lf_q_r;
    assign lf_fall = ~low_freq_clock & lf_q_r;

    // A task fires on the first rising edge after a falling edge
    assign fire = pend_r & fall_seen_r & {4{lf_rise}};

    // Keep the slow clock requested while running or a task is waiting
    assign lf_clk_req = running | (|pend_r);

    // Step only when running, no load this edge and the latch is zero
    assign inc = lf_rise & running & ~fire[2] & ~fire[3]
                 & (presc_r == `PRESC_ZERO);

    assign cnt_next = cnt_r + `CNT_W'h000001;

    // Edge history of the slow clock
    always @(posedge core_clk) begin
        if (srst) begin
            lf_q_r <= 1'b0;
        end else begin
            lf_q_r <= low_freq_clock;
        end
    end

    // Pending tasks wait for a falling then a rising slow edge
    always @(posedge core_clk) begin
        if (srst) begin
            pend_r      <= 4'h0;
            fall_seen_r <= 4'h0;
        end else begin
            // A fresh task restarts its wait; a new request beats completion
            pend_r      <= (pend_r & ~fire) | task_in;
            fall_seen_r <= ((fall_seen_r | ({4{lf_fall}} & pend_r)) & ~fire) & ~task_in;
        end
    end

    // Run state follows start and stop as they take effect
    always @(posedge core_clk) begin
        if (srst) begin
            running <= 1'b0;
        end else if (fire[1]) begin
            running <= 1'b0;
        end else if (fire[0]) begin
            running <= 1'b1;
        end
    end

    // Counter and prescale latch, all in step with the slow rising edge
    always @(posedge core_clk) begin
        if (srst) begin
            cnt_r           <= `CNT_RESET;
            presc_r         <= `PRESC_ZERO;
            increment_event <= 1'b0;
            wrap_event      <= 1'b0;
        end else begin
            increment_event <= inc;
            wrap_event      <= inc & (cnt_r == `CNT_MAX);
            if (fire[2]) begin
                cnt_r   <= `CNT_RESET;
                presc_r <= prescaler;
            end else if (fire[3]) begin
                cnt_r   <= `CNT_NEAR_WRAP;
                presc_r <= prescaler;
            end else if (inc) begin
                cnt_r   <= cnt_next;
                presc_r <= prescaler;
            end else if (lf_rise & running) begin
                presc_r <= presc_r - `PRESC_W'h001;
            end
            // Start restarts the latch without stepping the counter
            if (fire[0] & ~fire[2] & ~fire[3]) begin
                presc_r <= prescaler;
            end
        end
    end

    // Compare channels, evaluated only on counter steps
    genvar ch;
    generate
        for (ch = 0; ch < `CMP_CHANNELS; ch = ch + 1) begin : g_cmp
            rtc_cmp_channel u_cmp (
                .core_clk (core_clk),
                .srst     (srst),
                .wr       (cmp_wr[ch]),
                .wdata    (cmp_wdata),
                .lf_rise  (lf_rise),
                .inc      (inc),
                .cnt_next (cnt_next),
                .value    (),
                .match    (compare_event[ch])
            );
        end
    endgenerate

    // Read access: three stalled cycles, then ready with captured data
    assign pready = rd_sel & rd_enable & (rd_cnt_r == `RD_STALL_CYC);

    always @(posedge core_clk) begin
        if (srst) begin
            rd_cnt_r <= 3'd0;
            rd_data  <= `CNT_RESET;
        end else if (rd_sel & rd_enable & ~pready) begin
            rd_cnt_r <= rd_cnt_r + 3'd1;
            if (rd_cnt_r == `RD_CAPTURE_CYC) begin
                rd_data <= cnt_r;
            end
        end else begin
            rd_cnt_r <= 3'd0;
        end
    end

endmodule
`default_nettype wire

//--- bench/lf_src.sv
// Slow clock source model that runs only while requested
`timescale 1ns/1ps
`default_nettype none
module lf_src (
    input  wire logic core_clk,
    input  wire logic req,
    output var  logic lf
);
    logic [1:0] div_r = 2'h0;
    initial lf = 1'b0;
    // Toggle every four fast cycles, stand still otherwise
    always @(posedge core_clk) begin
        if (req) begin
            div_r <= div_r + 2'h1;
            if (div_r == 2'h3) lf <= ~lf;
        end
    end
endmodule
`default_nettype wire

//--- bench/rtc_core_asserts.sv
// Port checks on the counter core
`timescale 1ns/1ps
`default_nettype none
module rtc_core_asserts (
    input wire logic       core_clk,
    input wire logic       srst,
    input wire logic       task_start,
    input wire logic       task_stop,
    input wire logic       task_clear,
    input wire logic       task_force_near_overflow,
    input wire logic       rd_sel,
    input wire logic       rd_enable,
    input wire logic       pready,
    input wire logic       lf_clk_req,
    input wire logic       running,
    input wire logic       increment_event,
    input wire logic       wrap_event,
    input wire logic [3:0] compare_event
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (srst);
    sequence rd_open;
        rd_sel && $rose(rd_enable);
    endsequence
    sequence rd_stall;
        !pready [*3] ##1 pready;
    endsequence
    read_stall_a: assert property (rd_open |-> rd_stall)
        else $error("read stall length wrong");
    ready_once_a: assert property (pready |=> !pready)
        else $error("ready held too long");
    ready_sel_a: assert property (pready |-> rd_sel && rd_enable)
        else $error("ready outside a read");
    wrap_step_a: assert property (wrap_event |-> increment_event)
        else $error("wrap without a step");
    cmp_step_a: assert property (|compare_event |-> increment_event)
        else $error("compare without a step");
    step_gap_a: assert property (increment_event |=> !increment_event [*2])
        else $error("steps too close");
    step_run_a: assert property (increment_event |-> $past(running))
        else $error("step while stopped");
    run_req_a: assert property (running |-> lf_clk_req)
        else $error("slow clock not requested");
    task_req_a: assert property (task_start || task_stop || task_clear
        || task_force_near_overflow |=> lf_clk_req)
        else $error("pending task without request");
endmodule
`default_nettype wire

//--- bench/rtc_core_test.sv
// Self-checking bench for the counter core
`timescale 1ns/1ps
`default_nettype none
`include "rtc_consts.vh"
module rtc_core_test;
    logic        core_clk, srst, lf, rs, re, pready, lfr, run, inc, wrp;
    logic [3:0]  tk, cw, cev, ec, w;
    logic [11:0] presc;
    logic [23:0] wd, rd, cnt;
    logic [23:0] cc [4];
    logic [31:0] seed = 32'h3f;
    int          n_fail = 0, samples_checked = 0, n, ncev = 0, ne = 0;
    assign w = {run, !lfr, pready, inc};
    rtc_core rtc_core_inst (.core_clk(core_clk), .srst(srst), .low_freq_clock(lf),
        .task_start(tk[0]), .task_stop(tk[1]), .task_clear(tk[2]),
        .task_force_near_overflow(tk[3]), .prescaler(presc), .cmp_wr(cw), .cmp_wdata(wd),
        .rd_sel(rs), .rd_enable(re), .pready(pready), .rd_data(rd), .lf_clk_req(lfr),
        .running(run), .increment_event(inc), .wrap_event(wrp), .compare_event(cev));
    lf_src lf_src_inst (.core_clk(core_clk), .req(lfr), .lf(lf));
    // Clock and event pulse tally
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    always @(posedge core_clk) if (|cev === 1'b1) ncev++;
    function automatic logic [31:0] xs(input logic [31:0] v);
        v = v ^ (v << 13);
        v = v ^ (v >> 17);
        return v ^ (v << 5);
    endfunction
    task automatic chk(input string nm, input logic [23:0] e, input logic [23:0] s);
        samples_checked++;
        if (s !== e) begin
            n_fail++;
            $display("[ERR] %s exp %h got %h", nm, e, s);
        end
    endtask
    task automatic till(input int k);
        n = 0;
        do begin
            @(negedge core_clk);
            n++;
        end while (w[k] !== 1'b1 && n < 80);
        if (n >= 80) begin
            n_fail++;
            $display("[ERR] wait %0d exp 1 got 0", k);
        end
    endtask
    task automatic act(input logic [3:0] k, input int d);
        @(posedge core_clk);
        tk <= k;
        @(posedge core_clk);
        tk <= 4'h0;
        till(d);
    endtask
    task automatic rd_cnt(input logic [23:0] e);
        @(posedge core_clk);
        rs <= 1'b1;
        @(posedge core_clk);
        re <= 1'b1;
        till(1);
        chk("stall", 4, n);
        chk("count", e, rd);
        @(posedge core_clk);
        rs <= 1'b0;
        re <= 1'b0;
    endtask
    task automatic close_out();
        $display("checks %0d fails %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    // Watchdog
    initial begin
        #100us;
        n_fail++;
        close_out();
    end
    // Main sequence
    initial begin
        {tk, cw, wd, presc, rs, re} = '0;
        srst = 1'b1;
        repeat (16) @(posedge core_clk);
        srst <= 1'b0;
        act(4'h8, 2);
        rd_cnt(`CNT_NEAR_WRAP);
        seed = xs(seed);
        cc = '{24'hfffff2, 24'hfffff3 + seed % 12, 24'h000000, `CNT_NEAR_WRAP};
        for (int i = 0; i < 4; i++) begin
            @(posedge core_clk);
            cw <= 4'h1 << i;
            wd <= cc[i];
        end
        @(posedge core_clk);
        cw <= 4'h0;
        cnt = `CNT_NEAR_WRAP;
        act(4'h1, 3);
        for (int s = 0; s < 20; s++) begin
            till(0);
            cnt = cnt + 24'h1;
            for (int i = 0; i < 4; i++) ec[i] = (cc[i] == cnt);
            ne += (ec != 4'h0);
            chk("cmp", ec, cev);
            chk("wrap", cnt == 0, wrp);
        end
        act(4'h2, 2);
        act(4'h4, 2);
        rd_cnt(`CNT_RESET);
        // Start with the counter already equal to a compare value
        act(4'h1, 3);
        till(0);
        chk("cmp", 24'h0, cev);
        act(4'h2, 2);
        chk("events", ne, ncev);
        close_out();
    end
endmodule
bind rtc_core rtc_core_asserts rtc_core_asserts_inst (.core_clk(core_clk), .srst(srst),
    .task_start(task_start), .task_stop(task_stop), .task_clear(task_clear),
    .task_force_near_overflow(task_force_near_overflow), .rd_sel(rd_sel),
    .rd_enable(rd_enable), .pready(pready), .lf_clk_req(lf_clk_req), .running(running),
    .increment_event(increment_event), .wrap_event(wrap_event),
    .compare_event(compare_event));
`default_nettype wire
